// ### src/island_cfg_pkg.sv
`default_nettype none
package island_cfg_pkg;
   // clock and restore hold time
   localparam int unsigned CLK_HZ       = 100_000_000;
   localparam int unsigned HOLD_MS      = 2000;
   localparam int unsigned HOLD_CYC_DEF = (CLK_HZ / 1000) * HOLD_MS;

   // island geometry
   localparam int unsigned NUM_SLOTS  = 12;
   localparam int unsigned IDX_W      = 4;
   localparam int unsigned OUT_REGS   = 24;
   localparam int unsigned IN_REGS    = 48;

   // fieldbus register numbers: 40001 and 45392
   localparam logic [15:0] OUT_IMG_BASE = 16'h9C41;
   localparam logic [15:0] IN_IMG_BASE  = 16'hB150;

   // analog words are left-justified in the image
   localparam int unsigned ANA_BITS  = 12;
   localparam int unsigned ANA_SHIFT = 16 - ANA_BITS;

   typedef enum logic [2:0] {
      KIND_EMPTY, KIND_PDM, KIND_TERM, KIND_DIG_IN,
      KIND_DIG_OUT, KIND_RELAY, KIND_ANA_IN, KIND_ANA_OUT
   } mod_kind_t;

   typedef enum logic {ISL_STOPPED, ISL_OPERATIONAL} isl_state_t;

   // what one physical slot reports
   typedef struct packed {
      mod_kind_t   kind;
      logic [15:0] in_ch0;
      logic [15:0] in_ch1;
      logic [15:0] st_ch0;
      logic [15:0] st_ch1;
      logic [15:0] actual_out;
      logic        reflex;
   } slot_t;

   // command that goes with a flash store request
   typedef struct packed {
      logic keep_network;
      logic factory_defaults;
      logic auto_store;
   } flash_cmd_t;

   // output-image words that a module takes
   function automatic logic [15:0] out_len(mod_kind_t k);
      case (k)
         KIND_DIG_OUT, KIND_RELAY: out_len = 16'h0001;
         KIND_ANA_OUT:             out_len = 16'h0002;
         default:                  out_len = 16'h0000;
      endcase
   endfunction

   // input-image words that a module takes
   function automatic logic [15:0] in_len(mod_kind_t k);
      case (k)
         KIND_DIG_IN, KIND_DIG_OUT, KIND_ANA_OUT: in_len = 16'h0002;
         KIND_RELAY:                              in_len = 16'h0001;
         KIND_ANA_IN:                             in_len = 16'h0004;
         default:                                 in_len = 16'h0000;
      endcase
   endfunction
endpackage
`default_nettype wire

// ### src/island_default_reconfig_and_image_map.sv
// What this block does
// RQ1 - restore starts only after button held continuously two seconds
// RQ2 - button honoured only in edit mode; ignored entirely when protected
// RQ3 - restore never touches network settings such as node address
// RQ4 - a valid press with a new module auto-configures and stores flash
// RQ5 - stage one auto-addresses all I/O modules and derives factory defaults
// RQ6 - stage two replaces flash configuration with factory-default one
// RQ7 - stage three returns configuration port parameters to defaults
// RQ8 - stage four re-initialises island bus into operational mode
// RQ9 - operator removes memory card and selects edit mode beforehand
// RQ10 - power modules and termination plate get no address, no registers
// RQ11 - output image from 40001; digital one word, analog one per channel
// RQ12 - digital data in low bits, analog data in high bits
// RQ13 - input image from 45392, consecutive in island address order
// RQ14 - digital module: two words, data or echo, then status
// RQ15 - relay output module: exactly one status word
// RQ16 - echo shows applied value, actual output state under reflex
// RQ17 - two-channel analog input: data, status, data, status
// RQ18 - two-channel analog output: status ch1 then status ch2
// RQ19 - a press released before two seconds is discarded
`timescale 1ns/100ps
`default_nettype none
module island_default_reconfig_and_image_map
   import island_cfg_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = island_cfg_pkg::HOLD_CYC_DEF
) (
   input  wire logic                    core_clk_i,     // 100 MHz
   input  wire logic                    sys_rst_i,      // sync, high
   input  wire logic                    restore_btn_i,  // panel pin
   input  wire logic                    edit_mode_i,    // 0 = protected
   input  wire logic                    new_module_i,   // module added
   input  wire island_cfg_pkg::slot_t   slots_i [island_cfg_pkg::NUM_SLOTS],
   input  wire logic                    flash_done_i,   // store finished
   input  wire logic                    bus_ready_i,    // bus up
   input  wire logic                    mb_rd_i,        // master read
   input  wire logic                    mb_wr_i,        // master write
   input  wire logic [15:0]             mb_addr_i,      // register number
   input  wire logic [15:0]             mb_wdata_i,     // write data
   output logic [15:0]                  mb_rdata_o,     // read data
   output logic                         mb_ack_o,       // read/write done
   output logic [15:0]                  out_img_o [island_cfg_pkg::OUT_REGS],
   output logic                         flash_req_o,    // store request
   output island_cfg_pkg::flash_cmd_t   flash_cmd_o,    // store kind
   output logic                         cfg_port_rst_o, // cfg port pulse
   output logic                         bus_init_o,     // bus init level
   output island_cfg_pkg::isl_state_t   island_state_o, // stopped/run
   output logic                         restore_busy_o, // sequence active
   output logic [IDX_W-1:0]             num_addr_o      // modules mapped
);
   import island_cfg_pkg::*;

   typedef enum {ST_IDLE, ST_ADDR, ST_FLASH, ST_CFG, ST_BUS} seq_st_t;

   seq_st_t          state;
   logic             btn_m;
   logic             btn_s;
   logic             armed;
   logic [31:0]      hold_cnt;
   logic             restore_start;
   logic             restore_run;
   logic             store_new;
   logic [IDX_W-1:0] walk;
   logic [IDX_W-1:0] n_addr;
   logic [15:0]      out_ptr;
   logic [15:0]      in_ptr;
   mod_kind_t        addr_kind [NUM_SLOTS];
   logic [IDX_W-1:0] addr_slot [NUM_SLOTS];
   logic [15:0]      out_base  [NUM_SLOTS];
   logic [15:0]      in_base   [NUM_SLOTS];
   logic [15:0]      next_rdata;
   logic [15:0]      in_off;
   logic [15:0]      out_off;
   logic [15:0]      k;
   slot_t            s;

   // two flops before the pin is used anywhere
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         btn_m <= 1'b0;
         btn_s <= 1'b0;
      end else begin
         btn_m <= restore_btn_i;
         btn_s <= btn_m;
      end
   end

   // hold timer; one start per press, even if held for minutes
   assign restore_start = (state == ST_IDLE) && armed && btn_s &&
                          edit_mode_i && (hold_cnt == HOLD_CYCLES - 1); // RQ1
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         hold_cnt <= '0;
         armed    <= 1'b1;
      end else if (!btn_s || !edit_mode_i) begin
         hold_cnt <= '0; // RQ19
         armed    <= btn_s ? 1'b0 : 1'b1; // RQ2
      end else if (restore_start) begin
         hold_cnt <= '0;
         armed    <= 1'b0;
      end else if (armed && state == ST_IDLE) begin
         hold_cnt <= hold_cnt + 32'h0000_0001;
      end
   end

   // restore sequencer; also runs addressing once after reset
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state          <= ST_ADDR;
         restore_run    <= 1'b0;
         store_new      <= 1'b0;
         flash_req_o    <= 1'b0;
         flash_cmd_o    <= '0;
         cfg_port_rst_o <= 1'b0;
         bus_init_o     <= 1'b0;
         island_state_o <= ISL_STOPPED;
         restore_busy_o <= 1'b0;
      end else begin
         cfg_port_rst_o <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (restore_start) begin
                  state          <= ST_ADDR; // RQ5
                  restore_run    <= 1'b1;
                  store_new      <= new_module_i; // RQ4
                  island_state_o <= ISL_STOPPED;
                  restore_busy_o <= 1'b1;
               end
            end
            ST_ADDR: begin
               if (walk == IDX_W'(NUM_SLOTS - 1)) begin
                  if (restore_run) begin
                     state       <= ST_FLASH; // RQ6
                     flash_req_o <= 1'b1;
                     // network section is never part of the image
                     flash_cmd_o <= '{keep_network: 1'b1, // RQ3
                                      factory_defaults: 1'b1,
                                      auto_store: store_new}; // RQ4
                  end else begin
                     state      <= ST_BUS;
                     bus_init_o <= 1'b1;
                  end
               end
            end
            ST_FLASH: begin
               if (flash_done_i) begin
                  flash_req_o    <= 1'b0;
                  state          <= ST_CFG;
                  cfg_port_rst_o <= 1'b1; // RQ7
               end
            end
            ST_CFG: begin
               state      <= ST_BUS; // RQ8
               bus_init_o <= 1'b1;
            end
            ST_BUS: begin
               if (bus_ready_i) begin
                  bus_init_o     <= 1'b0;
                  island_state_o <= ISL_OPERATIONAL; // RQ8
                  restore_busy_o <= 1'b0;
                  restore_run    <= 1'b0;
                  state          <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // stage one walk: one slot per cycle, build the image map
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || restore_start) begin
         walk    <= '0;
         n_addr  <= '0;
         out_ptr <= '0;
         in_ptr  <= '0;
      end else if (state == ST_ADDR) begin
         if (walk != IDX_W'(NUM_SLOTS - 1)) begin
            walk <= walk + 1'b1;
         end
         // power and termination slots take no address
         if (slots_i[walk].kind != KIND_EMPTY &&
             slots_i[walk].kind != KIND_PDM &&
             slots_i[walk].kind != KIND_TERM) begin // RQ10
            addr_kind[n_addr] <= slots_i[walk].kind;
            addr_slot[n_addr] <= walk;
            out_base[n_addr]  <= out_ptr; // RQ11
            in_base[n_addr]   <= in_ptr; // RQ13
            out_ptr <= out_ptr + out_len(slots_i[walk].kind); // RQ11
            in_ptr  <= in_ptr + in_len(slots_i[walk].kind); // RQ13
            n_addr  <= n_addr + 1'b1;
         end
      end
   end
   assign num_addr_o = n_addr;

   a_skip_power: assert property (@(posedge core_clk_i) // RQ10
      disable iff (sys_rst_i)
      state == ST_ADDR && (slots_i[walk].kind inside {KIND_PDM, KIND_TERM})
      |=> n_addr == $past(n_addr) && in_ptr == $past(in_ptr))
      else $error("power or termination slot took an address");

   a_dig_two: assert property (@(posedge core_clk_i) // RQ14
      disable iff (sys_rst_i)
      state == ST_ADDR &&
      slots_i[walk].kind inside {KIND_DIG_IN, KIND_DIG_OUT} |=>
      in_ptr == $past(in_ptr) + 16'h0002)
      else $error("digital module did not take two input words");

   a_relay_one: assert property (@(posedge core_clk_i) // RQ15
      disable iff (sys_rst_i)
      state == ST_ADDR && slots_i[walk].kind == KIND_RELAY |=>
      in_ptr == $past(in_ptr) + 16'h0001)
      else $error("relay module did not take one status word");

   a_ana_in_four: assert property (@(posedge core_clk_i) // RQ17
      disable iff (sys_rst_i)
      state == ST_ADDR && slots_i[walk].kind == KIND_ANA_IN |=>
      in_ptr == $past(in_ptr) + 16'h0004)
      else $error("analog input module did not take four words");

   a_ana_out_two: assert property (@(posedge core_clk_i) // RQ18
      disable iff (sys_rst_i)
      state == ST_ADDR && slots_i[walk].kind == KIND_ANA_OUT |=>
      in_ptr == $past(in_ptr) + 16'h0002 &&
      out_ptr == $past(out_ptr) + 16'h0002)
      else $error("analog output module took wrong word count");

   // read decode over both images
   always_comb begin
      next_rdata = '0;
      k          = '0;
      s          = '0;
      out_off    = mb_addr_i - OUT_IMG_BASE;
      in_off     = mb_addr_i - IN_IMG_BASE;
      if (mb_addr_i >= OUT_IMG_BASE && out_off < out_ptr) begin
         next_rdata = out_img_o[out_off[4:0]]; // RQ11
      end
      for (int a = 0; a < NUM_SLOTS; a++) begin
         if (IDX_W'(a) < n_addr && mb_addr_i >= IN_IMG_BASE &&
             in_off >= in_base[a] &&
             in_off < in_base[a] + in_len(addr_kind[a])) begin
            k = in_off - in_base[a];
            s = slots_i[addr_slot[a]];
            case (addr_kind[a])
               KIND_DIG_IN: begin
                  next_rdata = k[0] ? s.st_ch0 : s.in_ch0; // RQ14
               end
               KIND_DIG_OUT: begin
                  // echo follows the real output under reflex control
                  if (k[0]) begin
                     next_rdata = s.st_ch0; // RQ14
                  end else if (s.reflex) begin
                     next_rdata = s.actual_out; // RQ16
                  end else begin
                     next_rdata = out_img_o[out_base[a][4:0]]; // RQ16
                  end
               end
               KIND_RELAY: next_rdata = s.st_ch0; // RQ15
               KIND_ANA_IN: begin
                  case (k[1:0]) // RQ17
                     2'h0:    next_rdata = s.in_ch0 << ANA_SHIFT; // RQ12
                     2'h1:    next_rdata = s.st_ch0;
                     2'h2:    next_rdata = s.in_ch1 << ANA_SHIFT; // RQ12
                     default: next_rdata = s.st_ch1;
                  endcase
               end
               KIND_ANA_OUT: begin
                  next_rdata = k[0] ? s.st_ch1 : s.st_ch0; // RQ18
               end
               default: next_rdata = '0;
            endcase
         end
      end
   end

   // master access; output image cleared to defaults in stage one
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || restore_start) begin
         mb_rdata_o <= '0;
         mb_ack_o   <= 1'b0;
         for (int i = 0; i < OUT_REGS; i++) begin
            out_img_o[i] <= '0;
         end
      end else begin
         mb_ack_o <= mb_rd_i || mb_wr_i;
         if (mb_rd_i) begin
            mb_rdata_o <= next_rdata;
         end
         // writes land only inside the mapped output range
         if (mb_wr_i && mb_addr_i >= OUT_IMG_BASE && out_off < out_ptr) begin
            out_img_o[out_off[4:0]] <= mb_wdata_i; // RQ12
         end
      end
   end

   // press history kept apart from the hold timer that it judges
   logic [31:0] press_len;
   logic        prot_seen;
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         press_len <= '0;
         prot_seen <= 1'b0;
      end else begin
         if (btn_s && edit_mode_i && press_len != '1) begin
            press_len <= press_len + 32'h0000_0001;
         end else if (!(btn_s && edit_mode_i)) begin
            press_len <= '0;
         end
         // a press that saw protected mode stays void until release
         prot_seen <= btn_s && (prot_seen || !edit_mode_i);
      end
   end

   a_hold_time: assert property (@(posedge core_clk_i) // RQ1
      disable iff (sys_rst_i)
      restore_start |-> press_len >= HOLD_CYCLES - 1)
      else $error("restore started without full hold");

   a_edit_whole: assert property (@(posedge core_clk_i) // RQ2
      disable iff (sys_rst_i)
      restore_start |-> !prot_seen)
      else $error("press that saw protected mode started restore");

   a_protected_ignore: assert property (@(posedge core_clk_i) // RQ2
      disable iff (sys_rst_i) !edit_mode_i |=> state != ST_ADDR ||
      $past(state) == ST_ADDR)
      else $error("restore began in protected mode");

   a_keep_network: assert property (@(posedge core_clk_i) // RQ3
      disable iff (sys_rst_i)
      flash_req_o |-> flash_cmd_o.keep_network && flash_cmd_o.factory_defaults)
      else $error("flash store would touch network settings");

   a_new_module_store: assert property (@(posedge core_clk_i) // RQ4
      disable iff (sys_rst_i)
      restore_start && new_module_i |=> store_new)
      else $error("new module press did not request auto store");

   a_addr_first: assert property (@(posedge core_clk_i) // RQ5
      disable iff (sys_rst_i)
      restore_start |=> state == ST_ADDR && walk == '0 && n_addr == '0)
      else $error("restore did not begin with addressing");

   a_flash_second: assert property (@(posedge core_clk_i) // RQ6
      disable iff (sys_rst_i)
      $rose(flash_req_o) |-> $past(state) == ST_ADDR && restore_run)
      else $error("flash store out of order");

   a_cfg_third: assert property (@(posedge core_clk_i) // RQ7
      disable iff (sys_rst_i)
      cfg_port_rst_o |-> $past(flash_done_i) ##1 bus_init_o)
      else $error("cfg port reset out of order");

   a_bus_fourth: assert property (@(posedge core_clk_i) // RQ8
      disable iff (sys_rst_i)
      $rose(island_state_o == ISL_OPERATIONAL) |->
      $past(bus_ready_i) && $past(bus_init_o))
      else $error("island went operational without bus init");

   a_short_press: assert property (@(posedge core_clk_i) // RQ19
      disable iff (sys_rst_i)
      $fell(btn_s) && state == ST_IDLE |=> hold_cnt == '0 && state == ST_IDLE)
      else $error("short press was not discarded");
endmodule // island_default_reconfig_and_image_map
`default_nettype wire

// ### verif/fieldbus_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// fieldbus master issuing one-cycle strobes against the process image
module fieldbus_master_model (
   input  wire logic        clk_i,   // core clock
   input  wire logic        ack_i,   // access done
   input  wire logic [15:0] rdata_i, // read data
   output logic             rd_o,    // read strobe
   output logic             wr_o,    // write strobe
   output logic [15:0]      addr_o,  // register number
   output logic [15:0]      wdata_o  // write data
);
   initial begin
      rd_o = 1'b0;
      wr_o = 1'b0;
      addr_o = 16'h0000;
      wdata_o = 16'h0000;
   end

   // ack must follow the taking edge at once; address and data stay put
   // until the edge after the taking edge, then are inverted so stale values never match
   task automatic access(input logic wr, input logic [15:0] a, d,
                         output logic [15:0] q, output logic ok);
      @(posedge clk_i);
      rd_o <= !wr;
      wr_o <= wr;
      addr_o <= a;
      wdata_o <= d;
      @(posedge clk_i);
      rd_o <= 1'b0;
      wr_o <= 1'b0;
      #1;
      ok = (ack_i === 1'b1);
      q = rdata_i;
      @(posedge clk_i);
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask
endmodule // fieldbus_master_model
`default_nettype wire

// ### verif/island_default_reconfig_and_image_map_tb.sv
`timescale 1ns/100ps
`default_nettype none
module island_default_reconfig_and_image_map_tb;
   import island_cfg_pkg::*;
   localparam int unsigned HOLD = 20;
   localparam logic [15:0] WR_DATA [6] = '{16'h0003, 16'h0001, 16'hA5A0,
      16'h5A50, 16'h003F, 16'hFFFF};
   localparam logic [15:0] IN_EXP [14] = '{16'h0015, 16'h0101, 16'h0003,
      16'h0202, 16'h0303, 16'hABC0, 16'h0404, 16'h1230, 16'h0405, 16'h0505,
      16'h0506, 16'h0029, 16'h0606, 16'h0000};
   logic             core_clk_i, sys_rst_i, restore_btn_i, edit_mode_i;
   logic             new_module_i, flash_done_i, bus_ready_i, mb_rd_i;
   logic             mb_wr_i, mb_ack_o, flash_req, cfg_port_rst, bus_init;
   logic             restore_busy;
   logic [15:0]      mb_addr_i, mb_wdata_i, mb_rdata_o;
   logic [15:0]      out_img [OUT_REGS];
   slot_t            slots [NUM_SLOTS];
   flash_cmd_t       flash_cmd;
   isl_state_t       island_state;
   logic [IDX_W-1:0] num_addr;
   int               mismatches = 0;
   int               tests_run = 0;

   island_default_reconfig_and_image_map #(.HOLD_CYCLES(HOLD)) u_dut (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .restore_btn_i(restore_btn_i), .edit_mode_i(edit_mode_i),
      .new_module_i(new_module_i), .slots_i(slots),
      .flash_done_i(flash_done_i), .bus_ready_i(bus_ready_i),
      .mb_rd_i(mb_rd_i), .mb_wr_i(mb_wr_i), .mb_addr_i(mb_addr_i),
      .mb_wdata_i(mb_wdata_i), .mb_rdata_o(mb_rdata_o), .mb_ack_o(mb_ack_o),
      .out_img_o(out_img), .flash_req_o(flash_req), .flash_cmd_o(flash_cmd),
      .cfg_port_rst_o(cfg_port_rst), .bus_init_o(bus_init),
      .island_state_o(island_state), .restore_busy_o(restore_busy),
      .num_addr_o(num_addr));

   fieldbus_master_model u_master (
      .clk_i(core_clk_i), .ack_i(mb_ack_o), .rdata_i(mb_rdata_o),
      .rd_o(mb_rd_i), .wr_o(mb_wr_i), .addr_o(mb_addr_i),
      .wdata_o(mb_wdata_i));

   // 100 MHz
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   task automatic check16(input logic [15:0] got, exp, input string what);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what,
                  got, exp);
      end
   endtask

   task automatic check1(input logic got, exp, input string what);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %b exp %b", $time, what,
                  got, exp);
      end
   endtask

   task automatic end_test(input string name);
      $display("test %s finished", name);
   endtask

   task automatic rd(input logic [15:0] a, exp, input string what);
      logic [15:0] q;
      logic        ok;
      u_master.access(1'b0, a, 16'h0000, q, ok);
      check1(ok, 1'b1, "read ack timing");
      check16(q, exp, what);
   endtask

   task automatic wr(input logic [15:0] a, d);
      logic [15:0] q;
      logic        ok;
      u_master.access(1'b1, a, d, q, ok);
      check1(ok, 1'b1, "write ack timing");
   endtask

   // neither sequence start nor flash store may appear for cyc cycles
   task automatic watch_idle(input int cyc, input string what);
      logic seen = 1'b0;
      repeat (cyc) begin
         @(posedge core_clk_i);
         #1;
         if (restore_busy !== 1'b0 || flash_req !== 1'b0) seen = 1'b1;
      end
      check1(seen, 1'b0, what);
   endtask

   // boot walk maps modules without any flash store
   task automatic t_boot;
      int   n;
      logic fl = 1'b0;
      for (n = 0; n < 40 && island_state !== ISL_OPERATIONAL; n++) begin
         @(posedge core_clk_i);
         #1;
         fl |= flash_req;
      end
      check1(island_state, ISL_OPERATIONAL, "boot operational");
      check16({12'h000, num_addr}, 16'h0006, "modules mapped");
      check1(fl, 1'b0, "no flash store at boot");
      end_test("boot");
   endtask

   // last write lands past the mapped output words and must be dropped
   task automatic t_out_map;
      for (int i = 0; i < 6; i++) wr(OUT_IMG_BASE + 16'(i), WR_DATA[i]);
      for (int i = 0; i < 5; i++) begin
         check16(out_img[i], WR_DATA[i], "out image");
      end
      check16(out_img[5], 16'h0000, "write past image");
      end_test("output image");
   endtask

   task automatic t_in_map;
      for (int i = 0; i < 5; i++) begin
         rd(IN_IMG_BASE + 16'(i), IN_EXP[i], "in");
      end
      for (int i = 5; i < 14; i++) begin
         rd(IN_IMG_BASE + 16'(i), IN_EXP[i], "in");
      end
      end_test("input image");
   endtask

   task automatic t_protected;
      @(posedge core_clk_i);
      edit_mode_i <= 1'b0;
      restore_btn_i <= 1'b1;
      watch_idle(HOLD + 10, "protected press");
      @(posedge core_clk_i);
      edit_mode_i <= 1'b1;
      watch_idle(HOLD + 10, "press held into edit");
      @(posedge core_clk_i);
      restore_btn_i <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      end_test("protected");
   endtask

   task automatic t_short;
      @(posedge core_clk_i);
      edit_mode_i <= 1'b1;
      restore_btn_i <= 1'b1;
      repeat (HOLD - 5) @(posedge core_clk_i);
      restore_btn_i <= 1'b0;
      watch_idle(HOLD + 10, "short press");
      end_test("short press");
   endtask

   // full sequence with flash and bus stalling before they answer
   task automatic t_restore(input logic nm);
      int n;
      wr(OUT_IMG_BASE, 16'h00FF);
      @(posedge core_clk_i);
      new_module_i <= nm;
      bus_ready_i <= 1'b0;
      restore_btn_i <= 1'b1;
      for (n = 0; n < HOLD + 12 && restore_busy !== 1'b1; n++) begin
         @(posedge core_clk_i);
         #1;
      end
      check1(n >= HOLD && restore_busy === 1'b1, 1'b1, "start after hold");
      @(posedge core_clk_i);
      restore_btn_i <= 1'b0;
      #1;
      check16(out_img[0], 16'h0000, "image cleared");
      check1(island_state, ISL_STOPPED, "stopped in sequence");
      for (n = 0; n < 20 && flash_req !== 1'b1; n++) begin
         @(posedge core_clk_i);
         #1;
      end
      check1(flash_req, 1'b1, "flash request");
      check16({13'h0000, flash_cmd}, {13'h0000, 2'b11, nm}, "flash cmd");
      check1(cfg_port_rst | bus_init, 1'b0, "stage order");
      check16({12'h000, num_addr}, 16'h0006, "addressed");
      repeat (3) @(posedge core_clk_i);
      flash_done_i <= 1'b1;
      @(posedge core_clk_i);
      flash_done_i <= 1'b0;
      #1;
      check1(cfg_port_rst & ~flash_req, 1'b1, "cfg port pulse");
      @(posedge core_clk_i);
      #1;
      check1(cfg_port_rst, 1'b0, "cfg pulse width");
      check1(bus_init, 1'b1, "bus init");
      repeat (2) @(posedge core_clk_i);
      bus_ready_i <= 1'b1;
      @(posedge core_clk_i);
      #1;
      check1(island_state, ISL_OPERATIONAL, "operational");
      check1(restore_busy, 1'b0, "busy released");
      rd(IN_IMG_BASE + 16'h0002, 16'h0000, "echo cleared");
      rd(IN_IMG_BASE + 16'h000B, 16'h0029, "reflex echo");
      end_test("restore");
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // slot order: kind, in0, in1, status0, status1, actual, reflex
   initial begin
      sys_rst_i = 1'b1;
      restore_btn_i = 1'b0;
      edit_mode_i = 1'b1;
      new_module_i = 1'b0;
      flash_done_i = 1'b0;
      bus_ready_i = 1'b1;
      for (int i = 0; i < NUM_SLOTS; i++) slots[i] = '0;
      slots[0] = '{KIND_DIG_IN, 16'h0015, 16'h0, 16'h0101, 16'h0, 16'h0, 1'b0};
      slots[1] = '{KIND_PDM, 16'hDEAD, 16'h0, 16'hBEEF, 16'h0, 16'h0, 1'b0};
      slots[2] = '{KIND_DIG_OUT, 16'h0, 16'h0, 16'h0202, 16'h0, 16'h7, 1'b0};
      slots[3] = '{KIND_RELAY, 16'h0, 16'h0, 16'h0303, 16'h0, 16'h0, 1'b0};
      slots[4] = '{KIND_ANA_IN, 16'h0ABC, 16'h0123, 16'h0404, 16'h0405,
                   16'h0, 1'b0};
      slots[5] = '{KIND_ANA_OUT, 16'h0, 16'h0, 16'h0505, 16'h0506,
                   16'h0, 1'b0};
      slots[6] = '{KIND_DIG_OUT, 16'h0, 16'h0, 16'h0606, 16'h0, 16'h29, 1'b1};
      slots[7] = '{KIND_TERM, 16'hDEAD, 16'h0, 16'hBEEF, 16'h0, 16'h0, 1'b0};
      repeat (5) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      t_boot;
      t_out_map;
      t_in_map;
      t_protected;
      t_short;
      t_restore(1'b0);
      t_restore(1'b1);
      give_verdict;
   end

   // all tests need well under a thousand cycles
   initial begin
      repeat (5000) @(posedge core_clk_i);
      mismatches++;
      $display("unexpected at %0t: watchdog expired", $time);
      give_verdict;
   end
endmodule // island_default_reconfig_and_image_map_tb
`default_nettype wire
